// ===== hdl/lft_rtc_wakeup.sv
`timescale 1ns/1ps
// How it works
// - Crystal present: low clock is divided 4kHz.
// - No crystal: low clock follows RC oscillator.
// - Clock/power register read shows low clock phase.
// - Tick every one plus divider periods.
// - Wakeup counter decrements once per tick.
// - Capture input gets half RC frequency.
// - 24-bit down counter reloads at zero.
// - Disabled at reset; low latch write enables.
// - Low latch write reloads the counter.
// - Disable code written stops the counter.
// - Read codes return latch or counter.
// - First wakeup N+1 to N+2 ticks.
// - Expiry sets the shared wakeup flag.
// - Expiry in power down forces exit.
// - Expiry pulses port0 pin0 for 1-16 ticks.
// - Nonzero clock/power write enters power down.
// - Control: busy bit4, write bit3, address.
// - Address 3: read counter, write disables.
// - Flag sticky; software set raises interrupt.
module lft_rtc_wakeup
    import lft_pkg::*;
#(
    parameter int COUNT_WIDTH = 24,
    parameter int PULSE_WIDTH = 4
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_b,
    // Special function register port.
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Clock sources.
    input wire logic crystal_present,
    input wire logic low_power_rc_osc,
    // Wakeup and power.
    input wire logic pin_wakeup,
    output logic wakeup_irq,
    output logic power_down,
    output logic power_down_exit,
    // Pins and capture.
    input wire logic pulse_out_enable,
    output logic port0_pin0,
    output logic timer2_capture_input,
    output logic lf_clock
);
    logic rc_sync;
    logic rc_q;
    logic xtal_sync;
    logic [15:0] lf_div_q;
    logic xtal_lf_q;
    logic lf_q;
    logic lf_edge;
    logic half_rc_q;
    logic tick;
    logic [7:0] tick_divider_q;
    logic [5:0] lf_clock_config_q;
    logic [7:0] clock_power_control_q;
    logic [7:0] data_high_q;
    logic [7:0] data_low_q;
    logic [3:0] ctrl_q;
    lft_xfer_type xfer_q;
    logic [1:0] xfer_cnt_q;
    logic [COUNT_WIDTH-1:0] latch_q;
    logic [COUNT_WIDTH-1:0] count_q;
    logic [PULSE_WIDTH-1:0] pulse_len_q;
    logic [PULSE_WIDTH-1:0] pulse_cnt_q;
    logic pulse_q;
    logic enabled_q;
    logic reload_q;
    logic flag_q;
    logic int_enable_q;
    logic expire;
    logic busy;
    logic ctrl_wr;
    logic do_xfer;
    logic [2:0] iaddr;
    logic [15:0] wdata16;
    logic [7:0] int_control_read;
    logic [7:0] int_enable_read;

    if (COUNT_WIDTH != 24 || PULSE_WIDTH < 1) begin : g_chk
        $error("Counter must be 24 bits and pulse field nonempty.");
    end

    lft_sync u_rc_sync (
        .clock(clock),
        .rst_b(rst_b),
        .async_in(low_power_rc_osc),
        .sync_out(rc_sync)
    );

    lft_sync u_xtal_sync (
        .clock(clock),
        .rst_b(rst_b),
        .async_in(crystal_present),
        .sync_out(xtal_sync)
    );

    // Low clock: crystal divider when present, else the RC oscillator.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lf_div_q <= '0;
            xtal_lf_q <= 1'b0;
        end else if (lf_div_q >= 16'(LF_HALF_CYCLES - 1)) begin
            lf_div_q <= '0;
            xtal_lf_q <= ~xtal_lf_q;
        end else begin
            lf_div_q <= lf_div_q + 16'h0001;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rc_q <= 1'b0;
            lf_q <= 1'b0;
            half_rc_q <= 1'b0;
        end else begin
            rc_q <= rc_sync;
            lf_q <= xtal_sync ? xtal_lf_q : rc_sync;
            if (rc_sync && !rc_q) begin
                half_rc_q <= ~half_rc_q;
            end
        end
    end

    // A rising edge of the selected low clock, one system clock wide.
    assign lf_edge = (xtal_sync ? xtal_lf_q : rc_sync) && !lf_q;
    assign lf_clock = lf_q;
    assign timer2_capture_input = half_rc_q;

    lft_tick_gen #(
        .WIDTH(8)
    ) u_tick (
        .clock(clock),
        .rst_b(rst_b),
        .lf_edge(lf_edge),
        .divider(tick_divider_q),
        .tick(tick)
    );

    // Plain register writes.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tick_divider_q <= TICK_DIVIDER_RESET;
            lf_clock_config_q <= LF_CLOCK_CONFIG_RESET;
            int_enable_q <= 1'b0;
        end else if (sfr_wr) begin
            unique case (sfr_addr)
                ADDR_TICK_DIVIDER: tick_divider_q <= sfr_wdata;
                ADDR_LF_CLOCK_CONFIG: lf_clock_config_q <= sfr_wdata[5:0];
                ADDR_EXT_INT_ENABLE: int_enable_q <= sfr_wdata[WAKEUP_ENABLE_BIT];
                default: ;
            endcase
        end
    end

    // A finished read refills the high byte even when another register is written.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            data_high_q <= 8'h00;
        end else if (sfr_wr && sfr_addr == ADDR_SLOW_DATA_HIGH) begin
            data_high_q <= sfr_wdata;
        end else if (xfer_q == LFT_DONE && !ctrl_q[CTRL_WRITE_BIT]) begin
            data_high_q <= wdata16[15:8];
        end
    end

    // Read results return through the data pair.
    always_comb begin
        wdata16 = 16'h0000;
        unique case (iaddr)
            IADDR_TIMER_HIGH: wdata16 = {count_q[23:16], latch_q[23:16]};
            IADDR_LATCH_LOW: wdata16 = latch_q[15:0];
            IADDR_COUNTER: wdata16 = count_q[15:0];
            default: wdata16 = 16'h0000;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            data_low_q <= 8'h00;
        end else if (sfr_wr && sfr_addr == ADDR_SLOW_DATA_LOW) begin
            data_low_q <= sfr_wdata;
        end else if (xfer_q == LFT_DONE && !ctrl_q[CTRL_WRITE_BIT]) begin
            data_low_q <= wdata16[7:0];
        end
    end

    // Slow-domain transfer sequencer.
    assign busy = (xfer_q != LFT_IDLE);
    assign ctrl_wr = sfr_wr && sfr_addr == ADDR_SLOW_CONTROL;
    assign iaddr = ctrl_q[CTRL_ADDR_MSB:0];
    assign do_xfer = (xfer_q == LFT_DONE);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= 4'h0;
            xfer_q <= LFT_IDLE;
            xfer_cnt_q <= 2'h0;
        end else begin
            unique case (xfer_q)
                LFT_IDLE: begin
                    if (ctrl_wr) begin
                        ctrl_q <= sfr_wdata[3:0];
                        xfer_cnt_q <= 2'h0;
                        xfer_q <= LFT_WAIT;
                    end
                end
                LFT_WAIT: begin
                    // New requests are dropped while busy.
                    if (lf_edge) begin
                        if (xfer_cnt_q == 2'(TRANSFER_LF_PERIODS - 1)) begin
                            xfer_q <= LFT_DONE;
                        end else begin
                            xfer_cnt_q <= xfer_cnt_q + 2'h1;
                        end
                    end
                end
                LFT_DONE: xfer_q <= LFT_IDLE;
                default: xfer_q <= LFT_IDLE;
            endcase
        end
    end

    // Wakeup counter, latch and pulse length.
    // Latch writes and the disable code arrive only through a finished transfer.
    assign expire = enabled_q && tick && !reload_q && count_q == '0;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            latch_q <= '0;
            pulse_len_q <= '0;
            enabled_q <= 1'b0;
            reload_q <= 1'b0;
        end else if (do_xfer && ctrl_q[CTRL_WRITE_BIT]) begin
            unique case (iaddr)
                IADDR_TIMER_HIGH: begin
                    latch_q[23:16] <= data_low_q;
                    pulse_len_q <= data_high_q[PULSE_WIDTH-1:0];
                end
                IADDR_LATCH_LOW: begin
                    latch_q[15:0] <= {data_high_q, data_low_q};
                    enabled_q <= 1'b1;
                    reload_q <= 1'b1;
                end
                IADDR_COUNTER: enabled_q <= 1'b0;
                default: ;
            endcase
        end else if (tick) begin
            reload_q <= 1'b0;
        end
    end

    // Decrement once per tick; a pending reload waits for the next tick.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= '0;
        end else if (enabled_q && tick) begin
            if (reload_q || count_q == '0) begin
                count_q <= latch_q;
            end else begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    // Pin pulse lasting pulse length plus one ticks.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pulse_q <= 1'b0;
            pulse_cnt_q <= '0;
        end else if (expire && pulse_out_enable) begin
            pulse_q <= 1'b1;
            pulse_cnt_q <= pulse_len_q;
        end else if (pulse_q && tick) begin
            if (pulse_cnt_q == '0) begin
                pulse_q <= 1'b0;
            end else begin
                pulse_cnt_q <= pulse_cnt_q - 1'b1;
            end
        end
    end

    assign port0_pin0 = pulse_q;

    // Wakeup flag: hardware set wins over software clear.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= 1'b0;
        end else if (expire || pin_wakeup) begin
            flag_q <= 1'b1;
        end else if (sfr_wr && sfr_addr == ADDR_EXT_INT_CONTROL) begin
            flag_q <= sfr_wdata[WAKEUP_FLAG_BIT];
        end
    end

    assign wakeup_irq = flag_q && int_enable_q;

    // Power down entry and forced exit.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            clock_power_control_q <= 8'h00;
        end else if (power_down && (expire || pin_wakeup)) begin
            clock_power_control_q <= 8'h00;
        end else if (sfr_wr && sfr_addr == ADDR_CLOCK_POWER_CONTROL) begin
            clock_power_control_q <= sfr_wdata;
        end
    end

    assign power_down = (clock_power_control_q != 8'h00);
    assign power_down_exit = power_down && (expire || pin_wakeup);

    // Reserved bits of the interrupt registers read back as the fixed patterns 8'h40 and 8'hE0.
    assign int_control_read = EXT_INT_CONTROL_FIXED | {4'h0, flag_q, 3'h0};
    assign int_enable_read = EXT_INT_ENABLE_FIXED | {3'h0, int_enable_q, 4'h0};

    // Register read mux.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                ADDR_SLOW_DATA_HIGH: sfr_rdata <= data_high_q;
                ADDR_SLOW_DATA_LOW: sfr_rdata <= data_low_q;
                ADDR_SLOW_CONTROL: sfr_rdata <= {3'h0, busy, ctrl_q};
                ADDR_TICK_DIVIDER: sfr_rdata <= tick_divider_q;
                ADDR_LF_CLOCK_CONFIG: sfr_rdata <= {2'h0, lf_clock_config_q};
                ADDR_CLOCK_POWER_CONTROL: sfr_rdata <= {lf_q, clock_power_control_q[6:0]};
                ADDR_EXT_INT_CONTROL: sfr_rdata <= int_control_read;
                ADDR_EXT_INT_ENABLE: sfr_rdata <= int_enable_read;
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end
endmodule : lft_rtc_wakeup

// ===== hdl/lft_pkg.sv
package lft_pkg;
    // Special function register addresses.
    localparam logic [7:0] ADDR_SLOW_DATA_HIGH = 8'hAB;
    localparam logic [7:0] ADDR_SLOW_DATA_LOW = 8'hAC;
    localparam logic [7:0] ADDR_SLOW_CONTROL = 8'hAD;
    localparam logic [7:0] ADDR_TICK_DIVIDER = 8'hB5;
    localparam logic [7:0] ADDR_CLOCK_POWER_CONTROL = 8'hB6;
    localparam logic [7:0] ADDR_LF_CLOCK_CONFIG = 8'hBF;
    localparam logic [7:0] ADDR_EXT_INT_CONTROL = 8'hD8;
    localparam logic [7:0] ADDR_EXT_INT_ENABLE = 8'hE8;
    // Reset values.
    localparam logic [7:0] TICK_DIVIDER_RESET = 8'h03;
    localparam logic [5:0] LF_CLOCK_CONFIG_RESET = 6'h27;
    // Slow domain control fields.
    localparam int CTRL_BUSY_BIT = 4;
    localparam int CTRL_WRITE_BIT = 3;
    localparam int CTRL_ADDR_MSB = 2;
    // Indirect addresses.
    localparam logic [2:0] IADDR_WATCHDOG = 3'h0;
    localparam logic [2:0] IADDR_TIMER_HIGH = 3'h1;
    localparam logic [2:0] IADDR_LATCH_LOW = 3'h2;
    localparam logic [2:0] IADDR_COUNTER = 3'h3;
    // Interrupt register bits.
    localparam int WAKEUP_FLAG_BIT = 3;
    localparam int WAKEUP_ENABLE_BIT = 4;
    localparam logic [7:0] EXT_INT_CONTROL_FIXED = 8'h40;
    localparam logic [7:0] EXT_INT_ENABLE_FIXED = 8'hE0;
    // Clock rates.
    localparam int SYS_CLOCK_HZ = 50000000;
    localparam int LF_CLOCK_HZ = 4000;
    localparam int LF_HALF_CYCLES = SYS_CLOCK_HZ / LF_CLOCK_HZ / 2;
    // Slow-domain transfer time, in low-frequency periods.
    localparam int TRANSFER_LF_PERIODS = 2;

    typedef enum logic [1:0] {
        LFT_IDLE = 2'b00,
        LFT_WAIT = 2'b01,
        LFT_DONE = 2'b10
    } lft_xfer_type;
endpackage : lft_pkg

// ===== hdl/lft_tick_gen.sv
`timescale 1ns/1ps
module lft_tick_gen
    import lft_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_b,
    // Control.
    input wire logic lf_edge,
    input wire logic [WIDTH-1:0] divider,
    // Result.
    output logic tick
);
    logic [WIDTH-1:0] count_q;

    if (WIDTH < 1) begin : g_chk
        $error("WIDTH must be positive.");
    end

    // The tick is one clock wide at the divider match.
    assign tick = lf_edge && (count_q >= divider);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= '0;
        end else if (lf_edge) begin
            if (count_q >= divider) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end
endmodule : lft_tick_gen

// ===== hdl/lft_sync.sv
`timescale 1ns/1ps
module lft_sync (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_b,
    // Data.
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : lft_sync

// ===== verification/lft_rtc_wakeup_assertions.sv
`timescale 1ns/1ps
module lft_rtc_wakeup_assertions
    import lft_pkg::*;
(
    // Watched top-level ports.
    input wire logic clock,
    input wire logic rst_b,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic crystal_present,
    input wire logic low_power_rc_osc,
    input wire logic pin_wakeup,
    input wire logic wakeup_irq,
    input wire logic power_down,
    input wire logic power_down_exit,
    input wire logic pulse_out_enable,
    input wire logic port0_pin0,
    input wire logic timer2_capture_input,
    input wire logic lf_clock
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    a_rdata_on_read: assert property ($changed(sfr_rdata) |-> $past(sfr_rd))
        else $error("read data moved without a read");
    a_div_readback: assert property (sfr_wr && sfr_addr == ADDR_TICK_DIVIDER ##2
        sfr_rd && sfr_addr == ADDR_TICK_DIVIDER |=> sfr_rdata == $past(sfr_wdata, 3))
        else $error("divider readback wrong");
    a_pd_enter: assert property (sfr_wr && sfr_addr == ADDR_CLOCK_POWER_CONTROL
        && sfr_wdata != 8'h00 |=> power_down)
        else $error("power down not entered");
    a_exit_in_pd: assert property (power_down_exit |-> power_down ##1 !power_down)
        else $error("exit pulse outside power down");
    a_pin_exit: assert property (power_down && $rose(pin_wakeup)
        |-> ##[0:3] power_down_exit)
        else $error("pin wakeup gave no exit");
    a_irq_mask: assert property (sfr_wr && sfr_addr == ADDR_EXT_INT_ENABLE
        && !sfr_wdata[WAKEUP_ENABLE_BIT] |=> !wakeup_irq)
        else $error("masked interrupt still high");
    a_irq_sticky: assert property (wakeup_irq && !(sfr_wr
        && (sfr_addr == ADDR_EXT_INT_CONTROL || sfr_addr == ADDR_EXT_INT_ENABLE)) |=> wakeup_irq)
        else $error("interrupt dropped by itself");
    a_sw_set: assert property (sfr_wr && sfr_addr == ADDR_EXT_INT_CONTROL
        && sfr_wdata[WAKEUP_FLAG_BIT] ##2 sfr_wr && sfr_addr == ADDR_EXT_INT_ENABLE
        && sfr_wdata[WAKEUP_ENABLE_BIT] |=> wakeup_irq)
        else $error("software flag set gave no interrupt");
    a_rc_follow: assert property ((!crystal_present && $stable(low_power_rc_osc)) [*6]
        |-> lf_clock == low_power_rc_osc)
        else $error("slow clock does not follow oscillator");
    a_phase_read: assert property ((sfr_rd && sfr_addr == ADDR_CLOCK_POWER_CONTROL
        && $stable(lf_clock)) ##1 $stable(lf_clock) |-> sfr_rdata[7] == lf_clock)
        else $error("phase bit wrong");
    a_pin_gate: assert property (!pulse_out_enable && !port0_pin0 |=> !port0_pin0)
        else $error("pulse while not allowed");

    c_pd_exit: cover property (power_down_exit);
    c_pulse: cover property ($rose(port0_pin0));
    c_irq: cover property (wakeup_irq);
endmodule : lft_rtc_wakeup_assertions

// ===== verification/lft_rc_osc_model.sv
`timescale 1ns/1ps
module lft_rc_osc_model #(
    parameter int HALF_NS = 200
) (
    // Oscillator output.
    output logic osc
);
    initial begin
        osc = 1'b0;
        forever begin
            #(HALF_NS);
            osc = ~osc;
        end
    end
endmodule : lft_rc_osc_model

// ===== verification/lft_rtc_wakeup_tb.sv
`timescale 1ns/1ps
module lft_rtc_wakeup_tb
    import lft_pkg::*;
;
    localparam int RC_HALF = 10;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic crystal_present = 1'b0;
    logic pin_wakeup = 1'b0;
    logic pulse_out_enable = 1'b0;
    logic [7:0] sfr_rdata;
    logic low_power_rc_osc, wakeup_irq, power_down, power_down_exit;
    logic port0_pin0, timer2_capture_input, lf_clock;
    logic [31:0] seed = 32'h2F64D510;
    int bad_count = 0;
    int check_count = 0;

    always #10 clock = ~clock;

    lft_rc_osc_model #(.HALF_NS(RC_HALF * 20)) i_osc (.osc(low_power_rc_osc));

    lft_rtc_wakeup i_dut (.clock(clock), .rst_b(rst_b), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .crystal_present(crystal_present), .low_power_rc_osc(low_power_rc_osc),
        .pin_wakeup(pin_wakeup), .wakeup_irq(wakeup_irq), .power_down(power_down),
        .power_down_exit(power_down_exit), .pulse_out_enable(pulse_out_enable),
        .port0_pin0(port0_pin0), .timer2_capture_input(timer2_capture_input),
        .lf_clock(lf_clock));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic int tk(input int dv);
        return (dv + 1) * 2 * RC_HALF;
    endfunction : tk

    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string s, input logic [23:0] e, input logic [23:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
        @(negedge clock);
        sfr_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        sfr_rd = 1'b1;
        sfr_addr = a;
        @(negedge clock);
        sfr_rd = 1'b0;
        @(negedge clock);
        d = sfr_rdata;
    endtask : rd

    task automatic ix(input logic w, input logic [2:0] a, input logic [15:0] d,
        output logic [15:0] q);
        logic [7:0] b;
        int n;
        wr(ADDR_SLOW_DATA_HIGH, d[15:8]);
        wr(ADDR_SLOW_DATA_LOW, d[7:0]);
        wr(ADDR_SLOW_CONTROL, {4'h0, w, a});
        b = 8'hFF;
        n = 0;
        while (b[CTRL_BUSY_BIT] !== 1'b0 && n < 200) begin
            rd(ADDR_SLOW_CONTROL, b);
            n++;
        end
        chk("busy", 1'b0, b[CTRL_BUSY_BIT]);
        rd(ADDR_SLOW_DATA_HIGH, q[15:8]);
        rd(ADDR_SLOW_DATA_LOW, q[7:0]);
    endtask : ix

    task automatic wait_pin(input logic v, output int n);
        n = 0;
        while (port0_pin0 !== v && n < 5000) begin
            @(negedge clock);
            n++;
        end
    endtask : wait_pin

    task automatic wait_chg(input logic sel, output int n);
        logic v;
        v = sel ? lf_clock : timer2_capture_input;
        n = 0;
        while ((sel ? lf_clock : timer2_capture_input) === v && n < 20000) begin
            @(negedge clock);
            n++;
        end
    endtask : wait_chg

    initial begin
        repeat (90000) @(posedge clock);
        bad_count++;
        end_sim;
    end

    initial begin
        logic [7:0] d;
        logic [15:0] q, q2;
        int n, m, nv, dv, pl, t;
        repeat (6) @(negedge clock);
        rst_b = 1'b1;
        repeat (2) @(negedge clock);
        pulse_out_enable = 1'b1;
        rd(ADDR_TICK_DIVIDER, d);
        chk("div_rst", TICK_DIVIDER_RESET, d);
        rd(ADDR_LF_CLOCK_CONFIG, d);
        chk("cfg_rst", LF_CLOCK_CONFIG_RESET, d[5:0]);
        ix(1'b0, IADDR_COUNTER, 16'h0000, q);
        chk("cnt_rst", 16'h0000, q);
        seed = lfsr(seed);
        wr(ADDR_LF_CLOCK_CONFIG, {2'b00, seed[13:8]});
        rd(ADDR_LF_CLOCK_CONFIG, d);
        chk("cfg_rw", seed[13:8], d[5:0]);
        wr(ADDR_LF_CLOCK_CONFIG, {2'b00, LF_CLOCK_CONFIG_RESET});
        wr(ADDR_TICK_DIVIDER, seed[7:0]);
        rd(ADDR_TICK_DIVIDER, d);
        chk("div_rw", seed[7:0], d);
        repeat (6) rd(ADDR_CLOCK_POWER_CONTROL, d);
        wait_chg(1'b0, n);
        wait_chg(1'b0, n);
        chk("cap_half", 2 * RC_HALF, n);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            nv = (i == 0) ? 1 : 2 + seed[2:0] % 6;
            dv = (i == 0) ? 0 : seed[9:8];
            pl = (i == 0) ? 0 : seed[14:12] % nv;
            t = tk(dv);
            ix(1'b1, IADDR_COUNTER, 16'h0000, q);
            wait_pin(1'b0, n);
            wr(ADDR_TICK_DIVIDER, 8'(dv));
            ix(1'b1, IADDR_TIMER_HIGH, {8'(pl), 8'h00}, q);
            ix(1'b1, IADDR_LATCH_LOW, 16'(nv), q);
            wait_pin(1'b1, n);
            chk("first_lo", 1'b1, n >= (nv + 1) * t - 16);
            chk("first_hi", 1'b1, n <= (nv + 2) * t + 16);
            wait_pin(1'b0, n);
            chk("pulse_len", (pl + 1) * t, n);
            wait_pin(1'b1, m);
            chk("period", (nv + 1) * t, n + m);
        end
        rd(ADDR_EXT_INT_CONTROL, d);
        chk("flag", EXT_INT_CONTROL_FIXED | 8'h08, d);
        wait_pin(1'b0, n);
        pulse_out_enable = 1'b0;
        wr(ADDR_CLOCK_POWER_CONTROL, 8'h01);
        chk("pd", 1'b1, power_down);
        n = 0;
        while (power_down_exit !== 1'b1 && n < 5000) begin
            @(negedge clock);
            n++;
        end
        chk("pd_exit", 1'b1, power_down_exit);
        wr(ADDR_CLOCK_POWER_CONTROL, 8'h00);
        chk("pin_off", 1'b0, port0_pin0);
        pulse_out_enable = 1'b1;
        wr(ADDR_SLOW_CONTROL, {4'h0, 1'b1, IADDR_COUNTER});
        ix(1'b1, IADDR_LATCH_LOW, 16'h0005, q);
        ix(1'b0, IADDR_COUNTER, 16'h0000, q);
        repeat (8 * t) @(negedge clock);
        ix(1'b0, IADDR_COUNTER, 16'h0000, q2);
        chk("frozen", q, q2);
        chk("pin_idle", 1'b0, port0_pin0);
        ix(1'b0, IADDR_TIMER_HIGH, 16'h0000, q);
        chk("latch_hi", 16'h0000, q);
        ix(1'b0, IADDR_LATCH_LOW, 16'h0000, q);
        chk("latch_lo", 16'(nv), q);
        wr(ADDR_CLOCK_POWER_CONTROL, 8'h01);
        pin_wakeup = 1'b1;
        #1;
        chk("pin_exit", 1'b1, power_down_exit);
        @(negedge clock);
        pin_wakeup = 1'b0;
        chk("pin_pd_off", 1'b0, power_down);
        wr(ADDR_CLOCK_POWER_CONTROL, 8'h00);
        wr(ADDR_EXT_INT_ENABLE, 8'h10);
        chk("irq_on", 1'b1, wakeup_irq);
        wr(ADDR_EXT_INT_ENABLE, 8'h00);
        wr(ADDR_EXT_INT_CONTROL, 8'h00);
        wr(ADDR_EXT_INT_ENABLE, 8'h10);
        chk("irq_clr", 1'b0, wakeup_irq);
        wr(ADDR_EXT_INT_CONTROL, 8'h08);
        wr(ADDR_EXT_INT_ENABLE, 8'h10);
        chk("irq_sw", 1'b1, wakeup_irq);
        wr(ADDR_EXT_INT_CONTROL, 8'h00);
        crystal_present = 1'b1;
        repeat (3) wait_chg(1'b1, n);
        chk("xtal_half", LF_HALF_CYCLES, n);
        end_sim;
    end
endmodule : lft_rtc_wakeup_tb

bind lft_rtc_wakeup lft_rtc_wakeup_assertions i_chk (.clock(clock), .rst_b(rst_b),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .crystal_present(crystal_present),
    .low_power_rc_osc(low_power_rc_osc), .pin_wakeup(pin_wakeup), .wakeup_irq(wakeup_irq),
    .power_down(power_down), .power_down_exit(power_down_exit),
    .pulse_out_enable(pulse_out_enable), .port0_pin0(port0_pin0),
    .timer2_capture_input(timer2_capture_input), .lf_clock(lf_clock));
